// ### hdl/dtsc_defs.svh
// constants for the debug trigger sequencer control block
// Notes on behaviour
// - armed: only arm and force bits writable
// - arm anytime; bits 5:0 only when disarmed
// - force-final bit writable anytime, reads zero
// - hardware disarm beats simultaneous software write
// - software disarm leaves low config bits
// - setting arm enters State1
// - arm clears when sequencer returns State0
// - software disarm raises no breakpoint
// - force-final one jumps final; zero ignored
// - target bit picks interrupt or background entry
// - cpu break enable gates breakpoint at State0
// - external event replaces channel 3 when enabled
// - mapping register readable, writable only disarmed
// - mapping codes select A and B, inside, outside
// - code 11 behaves as inside range
// - State1 register readable, writable only disarmed
// - State1 fields: ch0 1:0, ch1 3:2, ch3 7:6
// - setting 10: channel 3 follows external event
// - codes: none, State2, State3, final
// - highest numbered matching channel wins
// - only falling edge of event pin counts
// - event pin synchronised, seen two cycles later
`ifndef DTSC_DEFS_SVH
`define DTSC_DEFS_SVH

// register indices; byte address is four times the index
`define DTSC_IDX_C1      10'h100
`define DTSC_IDX_C2      10'h101
`define DTSC_IDX_SCR1    10'h107

`define DTSC_ARM_BIT     7
`define DTSC_FFR_BIT     6
`define DTSC_TGT_BIT     4
`define DTSC_CBE_BIT     3
`define DTSC_EEE_BIT     1

`define DTSC_RST_BYTE    8'h00
`define DTSC_ZERO_WORD   32'h0000_0000
`define DTSC_ZERO_PAD    24'h00_0000

`define DTSC_NS_NONE     2'h0
`define DTSC_NS_TWO      2'h1
`define DTSC_NS_THREE    2'h2
`define DTSC_NS_FINAL    2'h3

`define DTSC_AB_MATCH_MAPPING_AB     2'h0
`define DTSC_AB_MATCH_MAPPING_IN     2'h1
`define DTSC_AB_MATCH_MAPPING_OUT    2'h2
`define DTSC_AB_MATCH_MAPPING_RSV    2'h3

`define DTSC_EXTERNAL_EVENT_SETTING_EXT    2'h2

`define DTSC_RESP_OKAY   2'h0
`define DTSC_RESP_SLVERR 2'h2

`endif

// ### hdl/dtsc_pkg.sv
// types shared by the debug trigger sequencer control block
package dtsc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ONE,
        ST_TWO,
        ST_THREE,
        ST_FINAL
    } dtsc_state_t;

    typedef struct packed {
        logic comp_a;
        logic comp_b;
        logic ab_inside;
        logic ab_outside;
        logic comp_d;
    } dtsc_cmp_t;

    typedef struct packed {
        logic software_interrupt;
        logic background_mode;
    } dtsc_bkpt_t;

endpackage

// ### hdl/dtsc_top.sv
// debug trigger sequencer: control registers, State1 transitions, breakpoints
`timescale 1ns/1ps
`include "dtsc_defs.svh"

module dtsc_top
    import dtsc_pkg::*;
(
    input  wire logic        aclk,                     // bus clock
    input  wire logic        aresetn,                  // sync reset, low
    input  wire logic [11:0] s_axi_awaddr,             // write address
    input  wire logic        s_axi_awvalid,            // write address valid
    output logic             s_axi_awready,            // write address ready
    input  wire logic [31:0] s_axi_wdata,              // write data
    input  wire logic [3:0]  s_axi_wstrb,              // write strobes
    input  wire logic        s_axi_wvalid,             // write data valid
    output logic             s_axi_wready,             // write data ready
    output logic [1:0]       s_axi_bresp,              // write response
    output logic             s_axi_bvalid,             // write response valid
    input  wire logic        s_axi_bready,             // write response ready
    input  wire logic [11:0] s_axi_araddr,             // read address
    input  wire logic        s_axi_arvalid,            // read address valid
    output logic             s_axi_arready,            // read address ready
    output logic [31:0]      s_axi_rdata,              // read data
    output logic [1:0]       s_axi_rresp,              // read response
    output logic             s_axi_rvalid,             // read data valid
    input  wire logic        s_axi_rready,             // read data ready
    input  wire dtsc_cmp_t   cmp_in,                   // comparator matches
    input  wire logic        external_event_pin,       // external event
    input  wire logic        background_mode_active,   // cpu in background
    input  wire logic        background_controller_en, // controller enabled
    output dtsc_bkpt_t       bkpt_req,                 // breakpoint pulses
    output dtsc_state_t      seq_state,                // sequencer state
    output logic             armed                     // unit armed
);

    logic        aw_got_ff;
    logic        w_got_ff;
    logic [9:0]  waddr_ff;
    logic [7:0]  wdata_ff;
    logic        wlane_ff;
    logic        awready_ff;
    logic        wready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;

    logic        arm_ff;
    logic        bkpt_target_select_ff;
    logic        cpu_break_enable_ff;
    logic        external_event_enable_ff;
    logic [1:0]  ab_match_mapping_ff;
    logic [1:0]  chan0_next_state_ff;
    logic [1:0]  chan1_next_state_ff;
    logic [1:0]  chan3_next_state_ff;
    dtsc_state_t state_ff;
    dtsc_state_t nxt_state;
    dtsc_bkpt_t  bkpt_ff;

    logic        ev_sync1_ff;
    logic        ev_sync2_ff;
    logic        ev_last_ff;

    logic        wr_fire;
    logic        wr_c1;
    logic        wr_cfg;
    logic        wr_hit;
    logic        hw_disarm;
    logic        ext_event;
    logic [1:0]  external_event_setting;
    logic        match0;
    logic        match1;
    logic        match3;
    logic [1:0]  chan_next_state_code;
    logic        any_match;
    logic [7:0]  rd_byte;
    logic        rd_hit;

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign bkpt_req      = bkpt_ff;
    assign seq_state     = state_ff;
    assign armed         = arm_ff;

    // address and data are latched separately so either may come first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff  <= 1'b0;
            awready_ff <= 1'b1;
            waddr_ff   <= 10'h000;
        end else if (s_axi_awvalid && awready_ff) begin
            aw_got_ff  <= 1'b1;
            awready_ff <= 1'b0;
            waddr_ff   <= s_axi_awaddr[11:2];
        end else if (bvalid_ff && s_axi_bready) begin
            awready_ff <= 1'b1;
        end else if (wr_fire) begin
            aw_got_ff  <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_ff  <= 1'b0;
            wready_ff <= 1'b1;
            wdata_ff  <= `DTSC_RST_BYTE;
            wlane_ff  <= 1'b0;
        end else if (s_axi_wvalid && wready_ff) begin
            w_got_ff  <= 1'b1;
            wready_ff <= 1'b0;
            wdata_ff  <= s_axi_wdata[7:0];
            wlane_ff  <= s_axi_wstrb[0];
        end else if (bvalid_ff && s_axi_bready) begin
            wready_ff <= 1'b1;
        end else if (wr_fire) begin
            w_got_ff  <= 1'b0;
        end
    end

    assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_hit  = (waddr_ff == `DTSC_IDX_C1) || (waddr_ff == `DTSC_IDX_C2)
                     || (waddr_ff == `DTSC_IDX_SCR1);
    // the register byte needs lane 0; other lanes carry only zero bits
    assign wr_c1   = wr_fire && wlane_ff && (waddr_ff == `DTSC_IDX_C1);
    assign wr_cfg  = wr_fire && wlane_ff && !arm_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `DTSC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? `DTSC_RESP_OKAY : `DTSC_RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // locked writes still answer okay; software sees no error for them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bkpt_target_select_ff    <= 1'b0;
            cpu_break_enable_ff      <= 1'b0;
            external_event_enable_ff <= 1'b0;
        end else if (wr_cfg && waddr_ff == `DTSC_IDX_C1) begin
            bkpt_target_select_ff    <= wdata_ff[`DTSC_TGT_BIT];
            cpu_break_enable_ff      <= wdata_ff[`DTSC_CBE_BIT];
            external_event_enable_ff <= wdata_ff[`DTSC_EEE_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ab_match_mapping_ff <= `DTSC_AB_MATCH_MAPPING_AB;
        end else if (wr_cfg && waddr_ff == `DTSC_IDX_C2) begin
            ab_match_mapping_ff <= wdata_ff[1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan0_next_state_ff <= `DTSC_NS_NONE;
            chan1_next_state_ff <= `DTSC_NS_NONE;
            chan3_next_state_ff <= `DTSC_NS_NONE;
        end else if (wr_cfg && waddr_ff == `DTSC_IDX_SCR1) begin
            chan0_next_state_ff <= wdata_ff[1:0];
            chan1_next_state_ff <= wdata_ff[3:2];
            chan3_next_state_ff <= wdata_ff[7:6];
        end
    end

    // the final state is the internal disarm source
    assign hw_disarm = (state_ff == ST_FINAL);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arm_ff <= 1'b0;
        end else if (hw_disarm) begin
            arm_ff <= 1'b0;
        end else if (wr_c1) begin
            arm_ff <= wdata_ff[`DTSC_ARM_BIT];
        end
    end

    // first stage feeds only the second; edge seen on the settled copy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_sync1_ff <= 1'b1;
            ev_sync2_ff <= 1'b1;
            ev_last_ff  <= 1'b1;
        end else begin
            ev_sync1_ff <= external_event_pin;
            ev_sync2_ff <= ev_sync1_ff;
            ev_last_ff  <= ev_sync2_ff;
        end
    end

    assign ext_event = ev_last_ff && !ev_sync2_ff;
    assign external_event_setting = {external_event_enable_ff, 1'b0};

    always_comb begin
        case (ab_match_mapping_ff)
            `DTSC_AB_MATCH_MAPPING_AB: begin
                match0 = cmp_in.comp_a;
                match1 = cmp_in.comp_b;
            end
            `DTSC_AB_MATCH_MAPPING_OUT: begin
                match0 = cmp_in.ab_outside;
                match1 = 1'b0;
            end
            default: begin
                match0 = cmp_in.ab_inside;
                match1 = 1'b0;
            end
        endcase
    end

    assign match3 = (external_event_setting == `DTSC_EXTERNAL_EVENT_SETTING_EXT) ? ext_event
                                                               : cmp_in.comp_d;

    // highest matching channel decides even if its code is no effect
    always_comb begin
        any_match            = match3 || match1 || match0;
        chan_next_state_code = `DTSC_NS_NONE;
        if (match3) begin
            chan_next_state_code = chan3_next_state_ff;
        end else if (match1) begin
            chan_next_state_code = chan1_next_state_ff;
        end else if (match0) begin
            chan_next_state_code = chan0_next_state_ff;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        if (hw_disarm) begin
            nxt_state = ST_IDLE;
        end else if (wr_c1 && !wdata_ff[`DTSC_ARM_BIT]) begin
            nxt_state = ST_IDLE;
        end else if (wr_c1 && wdata_ff[`DTSC_FFR_BIT]) begin
            nxt_state = ST_FINAL;
        end else if (wr_c1 && !arm_ff) begin
            nxt_state = ST_ONE;
        end else if (arm_ff && state_ff == ST_ONE && any_match) begin
            case (chan_next_state_code)
                `DTSC_NS_TWO:   nxt_state = ST_TWO;
                `DTSC_NS_THREE: nxt_state = ST_THREE;
                `DTSC_NS_FINAL: nxt_state = ST_FINAL;
                default:        nxt_state = state_ff;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // only the hardware return to idle breaks; software disarm never does
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bkpt_ff <= '0;
        end else begin
            bkpt_ff.software_interrupt <= hw_disarm && cpu_break_enable_ff
                && !bkpt_target_select_ff && !background_mode_active;
            bkpt_ff.background_mode    <= hw_disarm && cpu_break_enable_ff
                && bkpt_target_select_ff && background_controller_en;
        end
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = `DTSC_RST_BYTE;
        case (s_axi_araddr[11:2])
            `DTSC_IDX_C1: begin
                rd_byte[`DTSC_ARM_BIT] = arm_ff;
                rd_byte[`DTSC_TGT_BIT] = bkpt_target_select_ff;
                rd_byte[`DTSC_CBE_BIT] = cpu_break_enable_ff;
                rd_byte[`DTSC_EEE_BIT] = external_event_enable_ff;
            end
            `DTSC_IDX_C2:   rd_byte[1:0] = ab_match_mapping_ff;
            `DTSC_IDX_SCR1: rd_byte = {chan3_next_state_ff, 2'h0,
                                       chan1_next_state_ff, chan0_next_state_ff};
            default:        rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= `DTSC_ZERO_WORD;
            rresp_ff   <= `DTSC_RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= {`DTSC_ZERO_PAD, rd_byte};
            rresp_ff   <= rd_hit ? `DTSC_RESP_OKAY : `DTSC_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_lock_cfg;
        arm_ff |=> $stable(ab_match_mapping_ff) && $stable(chan0_next_state_ff)
                   && $stable(chan1_next_state_ff) && $stable(chan3_next_state_ff);
    endproperty
    a_lock_cfg: assert property (p_lock_cfg)
        else $error("config changed while armed");

    property p_lock_c1;
        arm_ff |=> $stable(bkpt_target_select_ff) && $stable(cpu_break_enable_ff)
                   && $stable(external_event_enable_ff);
    endproperty
    a_lock_c1: assert property (p_lock_c1)
        else $error("control bits changed while armed");

    property p_ffr_reads_zero;
        rvalid_ff |-> !rdata_ff[`DTSC_FFR_BIT];
    endproperty
    a_ffr_reads_zero: assert property (p_ffr_reads_zero)
        else $error("force bit read back as one");

    property p_arm_enters_one;
        wr_c1 && wdata_ff[`DTSC_ARM_BIT] && !wdata_ff[`DTSC_FFR_BIT] && !arm_ff
            && !hw_disarm |=> state_ff == ST_ONE && arm_ff;
    endproperty
    a_arm_enters_one: assert property (p_arm_enters_one)
        else $error("arming did not enter state one");

    property p_final_returns;
        state_ff == ST_FINAL |=> state_ff == ST_IDLE && !arm_ff;
    endproperty
    a_final_returns: assert property (p_final_returns)
        else $error("final state did not return to idle");

    property p_hw_wins;
        wr_c1 && wdata_ff[`DTSC_ARM_BIT] && hw_disarm |=> !arm_ff;
    endproperty
    a_hw_wins: assert property (p_hw_wins)
        else $error("write beat hardware disarm");

    property p_sw_disarm_quiet;
        wr_c1 && !wdata_ff[`DTSC_ARM_BIT] && !hw_disarm |=> ##1 bkpt_ff == '0;
    endproperty
    a_sw_disarm_quiet: assert property (p_sw_disarm_quiet)
        else $error("software disarm raised a breakpoint");

    sequence s_force_write;
        wr_c1 && wdata_ff[`DTSC_ARM_BIT] && wdata_ff[`DTSC_FFR_BIT] && !hw_disarm;
    endsequence
    sequence s_final_then_idle;
        state_ff == ST_FINAL ##1 state_ff == ST_IDLE;
    endsequence
    property p_force_final;
        s_force_write |=> s_final_then_idle;
    endproperty
    a_force_final: assert property (p_force_final)
        else $error("force request did not reach final");

    property p_swi_route;
        hw_disarm && cpu_break_enable_ff && !bkpt_target_select_ff
            && !background_mode_active |=> bkpt_ff.software_interrupt
            && !bkpt_ff.background_mode;
    endproperty
    a_swi_route: assert property (p_swi_route)
        else $error("interrupt breakpoint missing");

    property p_break_gated;
        !(hw_disarm && cpu_break_enable_ff) |=> bkpt_ff == '0;
    endproperty
    a_break_gated: assert property (p_break_gated)
        else $error("breakpoint without enabled disarm");

    property p_ch3_priority;
        arm_ff && state_ff == ST_ONE && match3 && !wr_c1
            && chan3_next_state_ff == `DTSC_NS_FINAL |=> state_ff == ST_FINAL;
    endproperty
    a_ch3_priority: assert property (p_ch3_priority)
        else $error("channel three did not win");

    property p_map_inside;
        ab_match_mapping_ff[0] |-> !match1 && match0 == cmp_in.ab_inside;
    endproperty
    a_map_inside: assert property (p_map_inside)
        else $error("inside mapping wrong");

    sequence s_pin_fall;
        $fell(external_event_pin) ##1 !external_event_pin;
    endsequence
    property p_event_delay;
        s_pin_fall |=> ext_event;
    endproperty
    a_event_delay: assert property (p_event_delay)
        else $error("external event not seen two cycles on");

endmodule

// ### tb/dtsc_cpu_model.sv
// behavioural cpu core: takes breakpoint pulses and reports its background state
`timescale 1ns/1ps

module dtsc_cpu_model
    import dtsc_pkg::*;
(
    input  wire logic       aclk,                     // bus clock
    input  wire logic       aresetn,                  // sync reset, low
    input  wire dtsc_bkpt_t bkpt_req,                 // breakpoint pulses
    input  wire logic       bg_act_sel,               // bench: cpu in background
    input  wire logic       bg_en_sel,                // bench: controller enabled
    output logic            background_mode_active,   // cpu in background
    output logic            background_controller_en, // controller enabled
    output logic [7:0]      swi_cnt_ff,               // interrupts taken
    output logic [7:0]      bgm_cnt_ff                // background entries
);
    // levels follow the bench so each routing case can be set up on demand
    assign background_mode_active   = bg_act_sel;
    assign background_controller_en = bg_en_sel;

    // every pulse is one request; a stuck-high request would count each cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swi_cnt_ff <= 8'h00;
            bgm_cnt_ff <= 8'h00;
        end else begin
            swi_cnt_ff <= swi_cnt_ff + {7'h00, bkpt_req.software_interrupt};
            bgm_cnt_ff <= bgm_cnt_ff + {7'h00, bkpt_req.background_mode};
        end
    end
endmodule

// ### tb/debug_trigger_sequencer_control_tb_top.sv
// self-checking bench for the debug trigger sequencer control block
`timescale 1ns/1ps
`include "dtsc_defs.svh"

module debug_trigger_sequencer_control_tb_top
    import dtsc_pkg::*;
;
    localparam logic [11:0] A_C1   = {`DTSC_IDX_C1, 2'b00};
    localparam logic [11:0] A_C2   = {`DTSC_IDX_C2, 2'b00};
    localparam logic [11:0] A_SCR1 = {`DTSC_IDX_SCR1, 2'b00};
    localparam logic [11:0] A_BAD  = 12'h408;

    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, ext_pin, bg_act, bg_en, armed;
    logic        bg_act_sel, bg_en_sel;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rdat;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rrsp, last_resp;
    logic [7:0]  swi_cnt_ff, bgm_cnt_ff, exp_swi, exp_bgm;
    dtsc_cmp_t   cmp_in;
    dtsc_bkpt_t  bkpt_req;
    dtsc_state_t seq_state;
    int          bad_count, compares;

    dtsc_top u_dtsc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cmp_in(cmp_in), .external_event_pin(ext_pin),
        .background_mode_active(bg_act), .background_controller_en(bg_en),
        .bkpt_req(bkpt_req), .seq_state(seq_state), .armed(armed));

    dtsc_cpu_model u_dtsc_cpu_model (.aclk(aclk), .aresetn(aresetn), .bkpt_req(bkpt_req),
        .bg_act_sel(bg_act_sel), .bg_en_sel(bg_en_sel), .background_mode_active(bg_act),
        .background_controller_en(bg_en), .swi_cnt_ff(swi_cnt_ff), .bgm_cnt_ff(bgm_cnt_ff));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic tally_and_finish();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // called right after an edge; address and data go out together
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr  <= a;
        wdata   <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        last_resp = bresp;
    endtask

    task automatic rd(input logic [11:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rdat = rdata;
        rrsp = rresp;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        rd(a);
        chk(rdat, {24'h00_0000, exp});
    endtask

    task automatic bkchk();
        repeat (3) @(posedge aclk);
        chk(32'(swi_cnt_ff), 32'(exp_swi));
        chk(32'(bgm_cnt_ff), 32'(exp_bgm));
    endtask

    // comparator enables live outside this block, so every match counts
    // no profiling runs here, so re-arming straight after a session is fine
    task automatic arm_with(input logic [7:0] scr, input logic [7:0] map, input logic [7:0] c1);
        wr(A_C1, 8'h00);
        wr(A_SCR1, scr);
        wr(A_C2, map);
        wr(A_C1, c1);
        chk(32'(seq_state), 32'(ST_ONE));
    endtask

    task automatic hit(input dtsc_cmp_t m, input dtsc_state_t e);
        cmp_in <= m;
        @(posedge aclk);
        cmp_in <= '0;
        #1;
        chk(32'(seq_state), 32'(e));
        @(posedge aclk);
    endtask

    task automatic trial(input logic [7:0] scr, input logic [7:0] map, input logic [7:0] c1,
                         input dtsc_cmp_t m, input dtsc_state_t e);
        arm_with(scr, map, c1);
        hit(m, e);
    endtask

    task automatic bp(input logic [7:0] c1, input logic act, input logic en,
                      input logic s, input logic b);
        bg_act_sel <= act;
        bg_en_sel  <= en;
        wr(A_C1, 8'h00);
        wr(A_C1, c1);
        exp_swi = exp_swi + {7'h00, s};
        exp_bgm = exp_bgm + {7'h00, b};
        bkchk();
        chk(32'(armed), 32'h0);
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        {aresetn, awvalid, wvalid, arvalid, bg_act_sel, bg_en_sel} = '0;
        {awaddr, araddr, wdata, cmp_in, exp_swi, exp_bgm} = '0;
        {bready, rready, ext_pin, wstrb} = 7'h7F;
        bad_count = 0;
        compares = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(A_C1, 8'h00);
        rchk(A_C2, 8'h00);
        rchk(A_SCR1, 8'h00);
        wr(A_BAD, 8'hFF);
        chk(32'(last_resp), 32'(`DTSC_RESP_SLVERR));
        rd(A_BAD);
        chk(32'(rrsp), 32'(`DTSC_RESP_SLVERR));
        wr(A_C1, 8'h7F);
        chk(32'(last_resp), 32'(`DTSC_RESP_OKAY));
        rchk(A_C1, 8'h1A);
        // locked fields while armed
        arm_with(8'h00, 8'h00, 8'h88);
        wr(A_C1, 8'h80);
        rchk(A_C1, 8'h88);
        chk(32'(seq_state), 32'(ST_ONE));
        wr(A_C2, 8'h02);
        rchk(A_C2, 8'h00);
        wr(A_SCR1, 8'hFF);
        rchk(A_SCR1, 8'h00);
        wr(A_C1, 8'h00);
        rchk(A_C1, 8'h08);
        bkchk();
        // mapping codes, channel fields and priority
        trial(8'h01, 8'h00, 8'h88, 5'b10000, ST_TWO);
        trial(8'h08, 8'h00, 8'h88, 5'b01000, ST_THREE);
        trial(8'h00, 8'h00, 8'h88, 5'b10000, ST_ONE);
        trial(8'h01, 8'h01, 8'h88, 5'b00100, ST_TWO);
        trial(8'h04, 8'h01, 8'h88, 5'b01000, ST_ONE);
        trial(8'h01, 8'h02, 8'h88, 5'b00010, ST_TWO);
        trial(8'h01, 8'h02, 8'h88, 5'b10000, ST_ONE);
        trial(8'h01, 8'h03, 8'h88, 5'b00100, ST_TWO);
        trial(8'h04, 8'h03, 8'h88, 5'b01000, ST_ONE);
        trial(8'h49, 8'h00, 8'h88, 5'b11000, ST_THREE);
        trial(8'h49, 8'h00, 8'h88, 5'b11001, ST_TWO);
        trial(8'hC0, 8'h00, 8'h88, 5'b00001, ST_FINAL);
        exp_swi = exp_swi + 8'h01;
        bkchk();
        chk(32'(armed), 32'h0);
        // external event takes over channel 3
        trial(8'h40, 8'h00, 8'h8A, 5'b00001, ST_ONE);
        ext_pin <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
        chk(32'(seq_state), 32'(ST_ONE));
        @(posedge aclk);
        #1;
        chk(32'(seq_state), 32'(ST_TWO));
        arm_with(8'h40, 8'h00, 8'h8A);
        ext_pin <= 1'b1;
        repeat (5) @(posedge aclk);
        chk(32'(seq_state), 32'(ST_ONE));
        // breakpoint routing
        bp(8'hC8, 1'b0, 1'b0, 1'b1, 1'b0);
        bp(8'hC8, 1'b1, 1'b1, 1'b0, 1'b0);
        bp(8'hD8, 1'b0, 1'b1, 1'b0, 1'b1);
        bp(8'hD8, 1'b0, 1'b0, 1'b0, 1'b0);
        bp(8'hC0, 1'b0, 1'b1, 1'b0, 1'b0);
        bg_act_sel <= 1'b0;
        arm_with(8'h00, 8'h00, 8'h88);
        wr(A_C1, 8'hC0);
        exp_swi = exp_swi + 8'h01;
        bkchk();
        rchk(A_C1, 8'h08);
        // software write landing on the hardware disarm edge
        arm_with(8'hC0, 8'h00, 8'h88);
        fork
            wr(A_C1, 8'h88);
            hit(5'b00001, ST_FINAL);
        join
        exp_swi = exp_swi + 8'h01;
        bkchk();
        chk(32'(armed), 32'h0);
        tally_and_finish();
    end
endmodule
